// *** hw/cam_channel.sv ***
// one capture/compare channel driven by its mode byte
// assumes a synchronised pin input and a free-running main counter
`timescale 1ns/1ps
`default_nettype none
module cam_channel
	import cam_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic sys_rst_i,
	cam_chan_if.chan  ch
);
	// ******************************
	// decode
	// ******************************
	logic          eq_full;
	logic          eq_low;
	logic          eq_now;
	logic          eq_prev;
	logic          next_eq_prev;
	logic          pin_prev;
	logic          next_pin_prev;
	logic          rise;
	logic          fall;
	logic          match_evt;
	logic          cap_evt;
	logic [15:0]   cyc_mask;
	logic          pwm_level;
	logic          pin_q;
	logic          next_pin_q;
	logic          flag_q;
	logic          next_flag_q;
	logic [15:0]   cap_q;
	logic [15:0]   next_cap_q;
	logic          cap_p;
	logic          next_cap_p;
	logic          wdm_q;
	logic          next_wdm_q;
	cam_out_mode_t omode;

	always_comb begin
		// output mode first, the equality select below depends on it
		case ({ch.mode[CAM_TOGGLE_BIT], ch.mode[CAM_PWM_BIT]})
			2'b10: omode = CAM_OUT_TOGGLE;
			2'b01: omode = CAM_OUT_PWM;
			2'b11: omode = CAM_OUT_FREQ;
			default: omode = CAM_OUT_IDLE;
		endcase
		case (ch.cycle_len)
			2'h0: cyc_mask = 16'h00FF;
			2'h1: cyc_mask = 16'h01FF;
			2'h2: cyc_mask = 16'h03FF;
			default: cyc_mask = 16'h07FF;
		endcase
		// wide mode uses the whole word, else the shared cycle length
		if (ch.mode[CAM_WIDE_BIT]) begin
			cyc_mask = 16'hFFFF;
		end
		eq_full = ch.counter == ch.compare;
		eq_low  = ch.counter[7:0] == ch.compare[7:0];
		// frequency output compares only the low byte
		eq_now  = ch.mode[CAM_COMPARE_BIT] &&
			((omode == CAM_OUT_FREQ) ? eq_low : eq_full);
		// edge of equality, so a stopped counter matches once
		match_evt = eq_now && !eq_prev;
		rise = ch.pin_sync && !pin_prev;
		fall = !ch.pin_sync && pin_prev;
		cap_evt = (ch.mode[CAM_RISE_BIT] && rise)
			|| (ch.mode[CAM_FALL_BIT] && fall);
		pwm_level = (ch.counter & cyc_mask) < (ch.compare & cyc_mask);
	end

	// ******************************
	// next state
	// ******************************
	always_comb begin
		next_eq_prev  = eq_now;
		next_pin_prev = ch.pin_sync;
		next_pin_q    = pin_q;
		next_cap_q    = cap_q;
		next_cap_p    = 1'b0;
		next_flag_q   = flag_q;
		next_wdm_q    = 1'b0;
		if (ch.watchdog) begin
			// watchdog owns the channel; only the match is reported
			next_wdm_q = match_evt;
			next_pin_q = 1'b0;
		end else begin
			case (omode)
				CAM_OUT_TOGGLE: begin
					if (match_evt) begin
						next_pin_q = !pin_q;
					end
				end
				CAM_OUT_FREQ: begin
					if (match_evt) begin
						next_pin_q = !pin_q;
					end
				end
				CAM_OUT_PWM: begin
					next_pin_q = pwm_level;
				end
				default: begin
					next_pin_q = pin_q;
				end
			endcase
			if (cap_evt) begin
				next_cap_q = ch.counter;
				next_cap_p = 1'b1;
			end
			// clear first so a same-cycle event still sets the flag
			if (ch.flag_clear) begin
				next_flag_q = 1'b0;
			end
			if (cap_evt || (match_evt && ch.mode[CAM_MATCH_BIT])) begin
				next_flag_q = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			eq_prev  <= 1'b0;
			pin_prev <= 1'b0;
			pin_q    <= 1'b0;
			cap_q    <= CAM_WORD_RESET;
			cap_p    <= 1'b0;
			flag_q   <= 1'b0;
			wdm_q    <= 1'b0;
		end else begin
			eq_prev  <= next_eq_prev;
			pin_prev <= next_pin_prev;
			pin_q    <= next_pin_q;
			cap_q    <= next_cap_q;
			cap_p    <= next_cap_p;
			flag_q   <= next_flag_q;
			wdm_q    <= next_wdm_q;
		end
	end

	assign ch.pin_out        = pin_q;
	assign ch.pin_oe         = !ch.watchdog && (omode != CAM_OUT_IDLE);
	assign ch.flag           = flag_q;
	assign ch.capture        = cap_p;
	assign ch.captured       = cap_q;
	assign ch.watchdog_match = wdm_q;
endmodule
`default_nettype wire

// *** hw/cam_pkg.sv ***
// constants for the counter array module mode control block
// assumes one 50 MHz clock and an 8-bit internal register bus
package cam_pkg;
	localparam int          CAM_MODULES     = 3;
	localparam logic [7:0]  CAM_MODE0_ADDR  = 8'hDA;
	localparam logic [7:0]  CAM_MODE1_ADDR  = 8'hDB;
	localparam logic [7:0]  CAM_MODE2_ADDR  = 8'hDC;
	localparam logic [7:0]  CAM_MODE_RESET  = 8'h00;
	localparam int          CAM_WIDE_BIT    = 7;
	localparam int          CAM_COMPARE_BIT = 6;
	localparam int          CAM_RISE_BIT    = 5;
	localparam int          CAM_FALL_BIT    = 4;
	localparam int          CAM_MATCH_BIT   = 3;
	localparam int          CAM_TOGGLE_BIT  = 2;
	localparam int          CAM_PWM_BIT     = 1;
	localparam int          CAM_IRQ_BIT     = 0;
	localparam int          CAM_WDT_MODULE  = 2;
	localparam logic [15:0] CAM_WORD_RESET  = 16'h0000;
	typedef enum {
		CAM_OUT_IDLE,
		CAM_OUT_TOGGLE,
		CAM_OUT_PWM,
		CAM_OUT_FREQ
	} cam_out_mode_t;
endpackage

// *** hw/cam_chan_if.sv ***
// signals between the top and one capture/compare channel
// assumes both ends share clk_i
`timescale 1ns/1ps
`default_nettype none
interface cam_chan_if;
	logic [7:0]  mode;
	logic [15:0] counter;
	logic [15:0] compare;
	logic [1:0]  cycle_len;
	logic        pin_sync;
	logic        flag_clear;
	logic        watchdog;
	logic        pin_out;
	logic        pin_oe;
	logic        flag;
	logic        capture;
	logic [15:0] captured;
	logic        watchdog_match;
	modport top  (output mode, counter, compare, cycle_len, pin_sync, flag_clear, watchdog,
		input pin_out, pin_oe, flag, capture, captured, watchdog_match);
	modport chan (input mode, counter, compare, cycle_len, pin_sync, flag_clear, watchdog,
		output pin_out, pin_oe, flag, capture, captured, watchdog_match);
endinterface
`default_nettype wire

// *** hw/cam_top.sv ***
// mode registers and pin handling for three capture/compare modules
// assumes the counter, compare words and cycle length come from elsewhere
`timescale 1ns/1ps
`default_nettype none
module cam_top
	import cam_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic [7:0]  sfr_addr_i,
	input  wire logic        sfr_wr_i,
	input  wire logic [7:0]  sfr_wdata_i,
	output logic      [7:0]  sfr_rdata_o,
	output logic             sfr_hit_o,
	input  wire logic [15:0] counter_i,
	input  wire logic [15:0] compare0_i,
	input  wire logic [15:0] compare1_i,
	input  wire logic [15:0] compare2_i,
	input  wire logic [1:0]  cycle_len_i,
	input  wire logic        watchdog_enable_i,
	input  wire logic [2:0]  flag_clear_i,
	input  wire logic [2:0]  module_pin_i,
	output logic      [2:0]  module_pin_o,
	output logic      [2:0]  module_pin_oe_o,
	output logic      [2:0]  capture_compare_flag_o,
	output logic      [2:0]  capture_strobe_o,
	output logic      [47:0] captured_o,
	output logic             watchdog_match_o,
	output logic             flag_irq_o
);
	// ******************************
	// mode registers
	// ******************************
	logic [7:0] mode [CAM_MODULES];
	logic [7:0] next_mode [CAM_MODULES];
	logic [2:0] sel;
	logic [2:0] pin_meta;
	logic [2:0] pin_sync;
	logic [15:0] cmp [CAM_MODULES];
	logic [2:0] irq_vec;

	assign sel[0] = sfr_addr_i == CAM_MODE0_ADDR;
	assign sel[1] = sfr_addr_i == CAM_MODE1_ADDR;
	assign sel[2] = sfr_addr_i == CAM_MODE2_ADDR;
	assign cmp[0] = compare0_i;
	assign cmp[1] = compare1_i;
	assign cmp[2] = compare2_i;

	always_comb begin
		for (int i = 0; i < CAM_MODULES; i++) begin
			next_mode[i] = mode[i];
			if (sfr_wr_i && sel[i]) begin
				next_mode[i] = sfr_wdata_i;
			end
		end
		// a locked module 2 keeps its mode while the watchdog runs
		if (watchdog_enable_i) begin
			next_mode[CAM_WDT_MODULE] = mode[CAM_WDT_MODULE];
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < CAM_MODULES; i++) begin
				mode[i] <= CAM_MODE_RESET;
			end
		end else begin
			for (int i = 0; i < CAM_MODULES; i++) begin
				mode[i] <= next_mode[i];
			end
		end
	end

	// ******************************
	// read path and pin synchroniser
	// ******************************
	always_comb begin
		sfr_rdata_o = 8'h00;
		for (int i = 0; i < CAM_MODULES; i++) begin
			if (sel[i]) begin
				sfr_rdata_o = mode[i];
			end
		end
	end
	assign sfr_hit_o = |sel;

	// pins are asynchronous, so two stages before any edge logic
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pin_meta <= 3'h0;
			pin_sync <= 3'h0;
		end else begin
			pin_meta <= module_pin_i;
			pin_sync <= pin_meta;
		end
	end

	// ******************************
	// channels
	// ******************************
	cam_chan_if chan [CAM_MODULES] ();

	for (genvar g = 0; g < CAM_MODULES; g++) begin : g_chan
		assign chan[g].mode       = mode[g];
		assign chan[g].counter    = counter_i;
		assign chan[g].compare    = cmp[g];
		assign chan[g].cycle_len  = cycle_len_i;
		assign chan[g].pin_sync   = pin_sync[g];
		assign chan[g].flag_clear = flag_clear_i[g];
		assign chan[g].watchdog   = (g == CAM_WDT_MODULE) && watchdog_enable_i;
		cam_channel u_chan (
			.clk_i     (clk_i),
			.sys_rst_i (sys_rst_i),
			.ch        (chan[g])
		);
		assign module_pin_o[g]           = chan[g].pin_out;
		assign module_pin_oe_o[g]        = chan[g].pin_oe;
		assign capture_compare_flag_o[g] = chan[g].flag;
		assign capture_strobe_o[g]       = chan[g].capture;
		assign captured_o[16*g +: 16]    = chan[g].captured;
		assign irq_vec[g] = chan[g].flag && mode[g][CAM_IRQ_BIT];
	end

	assign watchdog_match_o = chan[CAM_WDT_MODULE].watchdog_match;
	assign flag_irq_o       = |irq_vec;
endmodule
`default_nettype wire

// *** verif/cam_pin_model.sv ***
// pin side model: drives each pin unless the block drives it
// assumes the bench sets the outside level on ext_i
`timescale 1ns/1ps
`default_nettype none
module cam_pin_model (
	input  wire logic [2:0] ext_i,
	input  wire logic [2:0] oe_i,
	input  wire logic [2:0] drv_i,
	output logic      [2:0] pin_o
);
	// ********
	// wire level
	// ********
	// the block wins while its enable is high
	assign pin_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule
`default_nettype wire

// *** verif/cam_top_chk.sv ***
// port checker for cam_top, module 0 mode mirrored from writes
// assumes bind onto cam_top
`timescale 1ns/1ps
`default_nettype none
module cam_top_chk (
	input wire logic        clk_i,
	input wire logic        sys_rst_i,
	input wire logic [7:0]  sfr_addr_i,
	input wire logic        sfr_wr_i,
	input wire logic [7:0]  sfr_wdata_i,
	input wire logic [7:0]  sfr_rdata_o,
	input wire logic        sfr_hit_o,
	input wire logic [15:0] counter_i,
	input wire logic [15:0] compare0_i,
	input wire logic        watchdog_enable_i,
	input wire logic [2:0]  module_pin_i,
	input wire logic [2:0]  module_pin_o,
	input wire logic [2:0]  module_pin_oe_o,
	input wire logic [2:0]  capture_compare_flag_o,
	input wire logic [2:0]  capture_strobe_o,
	input wire logic [47:0] captured_o
);
	// ********
	// checks
	// ********
	logic [7:0] m0;
	always_ff @(posedge clk_i)
		m0 <= sys_rst_i ? 8'h00 : (sfr_wr_i && sfr_addr_i == 8'hDA) ? sfr_wdata_i : m0;
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	a_hit_decode: assert property (sfr_hit_o == (sfr_addr_i inside {8'hDA, 8'hDB, 8'hDC}))
		else $error("hit wrong");
	a_write_read: assert property (sfr_wr_i && sfr_addr_i == 8'hDA |=>
		sfr_addr_i != 8'hDA || sfr_rdata_o == $past(sfr_wdata_i)) else $error("readback");
	a_wdt_lock: assert property (sfr_wr_i && watchdog_enable_i && sfr_addr_i == 8'hDC |=>
		sfr_addr_i != 8'hDC || $stable(sfr_rdata_o)) else $error("locked write");
	a_match_flag: assert property (m0[6] && m0[3] && $rose(counter_i == compare0_i) |=>
		capture_compare_flag_o[0]) else $error("no match flag");
	a_flag_cause: assert property ($rose(capture_compare_flag_o[0]) |->
		capture_strobe_o[0] || $past(m0[6])) else $error("flag without cause");
	a_match_toggle: assert property (m0[6] && m0[2] && !m0[1] &&
		$rose(counter_i == compare0_i) |=> module_pin_o[0] != $past(module_pin_o[0]))
		else $error("no toggle");
	a_pin_drive: assert property (module_pin_oe_o[0] == (m0[2] || m0[1]))
		else $error("pin enable");
	a_rise_capture: assert property (m0[5] && $rose(module_pin_i[0]) |-> ##3
		capture_strobe_o[0]) else $error("no capture");
	a_capture_word: assert property (capture_strobe_o[0] |->
		captured_o[15:0] == $past(counter_i)) else $error("captured word");
endmodule
bind cam_top cam_top_chk u_chk (.clk_i, .sys_rst_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i,
	.sfr_rdata_o, .sfr_hit_o, .counter_i, .compare0_i, .watchdog_enable_i, .module_pin_i,
	.module_pin_o, .module_pin_oe_o, .capture_compare_flag_o, .capture_strobe_o, .captured_o);
`default_nettype wire

// *** verif/cam_top_tb_top.sv ***
// self-checking bench for cam_top
// assumes cam_pin_model on the pins, checker bound
`timescale 1ns/1ps
`default_nettype none
module cam_top_tb_top;
	// ********
	// bench
	// ********
	logic        clk_i = 0, sys_rst_i = 1, sfr_wr_i = 0, watchdog_enable_i = 0;
	logic        sfr_hit_o, flag_irq_o, wd_match;
	logic [7:0]  sfr_addr_i = 0, sfr_wdata_i = 0, sfr_rdata_o;
	logic [15:0] counter_i = 0, compare0_i = 16'h0010, compare1_i = 16'h0080;
	logic [15:0] compare2_i = 16'h0000;
	logic [1:0]  cycle_len_i = 0;
	logic [2:0]  flag_clear_i = 0, ext = 0, pin_i, pin_o, pin_oe, flag, strobe;
	logic [47:0] captured;
	int          mismatches = 0, n_compared = 0;
	cam_top u_cam_top (.clk_i, .sys_rst_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .sfr_rdata_o,
		.sfr_hit_o, .counter_i, .compare0_i, .compare1_i, .compare2_i, .cycle_len_i,
		.watchdog_enable_i, .flag_clear_i, .module_pin_i(pin_i), .module_pin_o(pin_o),
		.module_pin_oe_o(pin_oe), .capture_compare_flag_o(flag), .capture_strobe_o(strobe),
		.captured_o(captured), .watchdog_match_o(wd_match), .flag_irq_o);
	cam_pin_model u_cam_pin_model (.ext_i(ext), .oe_i(pin_oe), .drv_i(pin_o), .pin_o(pin_i));
	initial forever #10 clk_i = ~clk_i;
	task automatic ck(input logic [15:0] g, input logic [15:0] e);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("Error at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		@(negedge clk_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		sfr_addr_i <= a;
		sfr_wr_i <= 1;
		sfr_wdata_i <= d;
		@(posedge clk_i);
		sfr_wr_i <= 0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_i);
		sfr_addr_i <= a;
		@(negedge clk_i);
		ck({7'h00, sfr_hit_o, sfr_rdata_o}, {7'h00, a inside {8'hDA, 8'hDB, 8'hDC}, e});
	endtask
	task automatic t_regs;
		for (int i = 0; i < 3; i++) rd(8'hDA + i, 8'h00);
		for (int i = 0; i < 3; i++) wr(8'hDA + i, 8'hA5 ^ i);
		for (int i = 0; i < 3; i++) rd(8'hDA + i, 8'hA5 ^ i);
		rd(8'hDD, 8'h00);
		@(posedge clk_i);
		watchdog_enable_i <= 1;
		wr(8'hDC, 8'h3C);
		rd(8'hDC, 8'hA7);
		@(posedge clk_i);
		watchdog_enable_i <= 0;
		$display("regs done");
	endtask
	task automatic t_match;
		wr(8'hDA, 8'h4D);
		counter_i <= 16'h000F;
		cyc(2);
		@(posedge clk_i);
		counter_i <= 16'h0010;
		cyc(1);
		ck({pin_i[0], flag[0], flag_irq_o}, 3'b111);
		@(posedge clk_i);
		flag_clear_i <= 3'b001;
		wr(8'hDA, 8'h0D);
		flag_clear_i <= 3'b000;
		counter_i <= 16'h0000;
		cyc(2);
		@(posedge clk_i);
		counter_i <= 16'h0010;
		cyc(2);
		ck({pin_i[0], flag[0], flag_irq_o}, 3'b100);
		$display("match done");
	endtask
	task automatic t_capture;
		// dropping the pin drive makes a falling edge, captured first
		wr(8'hDA, 8'h30);
		cyc(5);
		@(posedge clk_i);
		flag_clear_i <= 3'b001;
		counter_i <= 16'h1234;
		@(posedge clk_i);
		flag_clear_i <= 3'b000;
		ext <= 3'b001;
		cyc(3);
		ck({strobe[0], flag[0], flag_irq_o}, 3'b110);
		ck(captured[15:0], 16'h1234);
		@(posedge clk_i);
		counter_i <= 16'h5678;
		ext <= 3'b000;
		cyc(3);
		ck(strobe[0], 1'b1);
		ck(captured[15:0], 16'h5678);
		wr(8'hDA, 8'h20);
		counter_i <= 16'h9ABC;
		ext <= 3'b001;
		cyc(6);
		ck(captured[15:0], 16'h9ABC);
		@(posedge clk_i);
		counter_i <= 16'hDEF0;
		ext <= 3'b000;
		cyc(6);
		ck(captured[15:0], 16'h9ABC);
		$display("capture done");
	endtask
	task automatic t_watchdog;
		wr(8'hDC, 8'h40);
		counter_i <= 16'h0001;
		watchdog_enable_i <= 1;
		cyc(2);
		@(posedge clk_i);
		counter_i <= 16'h0000;
		cyc(1);
		ck({wd_match, pin_oe[2]}, 2'b10);
		cyc(1);
		ck(wd_match, 1'b0);
		@(posedge clk_i);
		watchdog_enable_i <= 0;
		$display("watchdog done");
	endtask
	task automatic t_pwm;
		wr(8'hDB, 8'h02);
		counter_i <= 16'h0210;
		cyc(3);
		ck({pin_oe[1], pin_i[1]}, 2'b11);
		wr(8'hDB, 8'h82);
		cyc(3);
		ck({pin_oe[1], pin_i[1]}, 2'b10);
		$display("pwm done");
	endtask
	task automatic print_verdict;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// whole run needs well under 20 us
	initial begin
		#200000;
		mismatches++;
		print_verdict();
	end
	initial begin
		repeat (16) @(posedge clk_i);
		sys_rst_i <= 0;
		t_regs();
		t_match();
		t_capture();
		t_pwm();
		t_watchdog();
		print_verdict();
	end
endmodule
`default_nettype wire
